/* common/sfp_pkg.sv */
// Purpose: Shared constants and types of the serial flash port front end
// Assumes: One 200 MHz core clock; serial pins are asynchronous to it
// Notes:   Operation times are typical figures; counts derive from them
//
// How it works
// - Link runs in clock mode 0 or 3; idle clock level at select is free.
// - Single lane: lane zero input is sampled on rising serial clock edges.
// - Single lane: read data leaves on lane one, changed on falling edges.
// - Dual and quad lanes are two-way: sample on rising, drive on falling.
// - Dual uses lanes zero and one; quad adds lanes two and three.
// - Select high deselects the port and releases every output lane.
// - A started erase, program or status write runs on after deselect.
// - Select low selects the port so it takes bits and may return data.
// - After power-up nothing is taken until select falls from high to low.
// - Protect pin held low can block writes to the status register.
// - Protect pin with protect bits and lock bit flags an array hardware lock; program and erase still run.
// - Protect function only in single and dual mode; quad uses it as data.
// - Array is 16 MiB: 256 blocks, 4096 sectors, 65536 pages.
// - Sector n starts at n times 0x1000; sixteen sectors per block.
// - One page program writes from 1 to 256 bytes.
// - Programming only clears bits; each page programs on its own.
// - Erase by sector, block or whole chip, never by page.
package sfp_pkg;
  localparam int ADDR_W            = 24;
  localparam int ARRAY_BYTES       = 16777216;
  localparam int NUM_BLOCKS        = 256;
  localparam int NUM_SECTORS       = 4096;
  localparam int NUM_PAGES         = 65536;
  localparam int SECTORS_PER_BLOCK = 16;
  localparam int PAGE_LSB          = 8;
  localparam int SECTOR_LSB        = 12;
  localparam int BLOCK_LSB         = 16;
  localparam logic [23:0] SECTOR_MASK = 24'h000fff;
  localparam logic [23:0] BLOCK_MASK  = 24'h00ffff;
  localparam logic [23:0] TOP_ADDR    = 24'hffffff;
  localparam logic [8:0]  PROG_MIN    = 9'h001;
  localparam logic [8:0]  PROG_MAX    = 9'h100;
  // Timing, in printed units, then in core cycles
  localparam longint CLK_PERIOD_PS     = 5000;
  localparam longint PROG_TIME_US      = 800;
  localparam longint SECT_ERASE_MS     = 50;
  localparam longint BLOCK_ERASE_MS    = 200;
  localparam longint CHIP_ERASE_S      = 45;
  localparam longint PROG_CYC        = PROG_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam longint SECT_ERASE_CYC  = SECT_ERASE_MS * 1000000000 / CLK_PERIOD_PS;
  localparam longint BLOCK_ERASE_CYC = BLOCK_ERASE_MS * 1000000000 / CLK_PERIOD_PS;
  localparam longint CHIP_ERASE_CYC  = CHIP_ERASE_S * 64'he8d4a51000 / CLK_PERIOD_PS;
  localparam int     STATUS_WR_CYC   = 16;

  typedef enum logic [1:0] {
    LANES_ONE  = 2'h0,
    LANES_TWO  = 2'h1,
    LANES_FOUR = 2'h3
  } sfp_lanes_t;

  typedef enum logic [2:0] {
    OP_PROGRAM      = 3'h0,
    OP_SECTOR_ERASE = 3'h1,
    OP_BLOCK_ERASE  = 3'h2,
    OP_CHIP_ERASE   = 3'h3,
    OP_STATUS_WRITE = 3'h4,
    OP_PAGE_ERASE   = 3'h5
  } sfp_op_t;

  typedef enum logic [1:0] {
    ST_WAIT_HIGH = 2'h0,
    ST_WAIT_LOW  = 2'h1,
    ST_SEL       = 2'h3,
    ST_IDLE      = 2'h2
  } sfp_link_t;

  typedef struct packed {
    logic [7:0]  block;
    logic [11:0] sector;
    logic [15:0] page;
    logic [7:0]  offset;
  } sfp_map_t;
endpackage

/* rtl/sfp_serial_port.sv */
// Purpose: Serial pin front end, protect pin logic and array map of the flash
// Assumes: Instruction decoder outside sets lane mode and output phase
// Notes:   Serial clock is oversampled; it must stay well below CLK_IN / 4
`timescale 1ns/1ps
`default_nettype none
module sfp_serial_port #(
  parameter logic [33:0] PROG_CYCLES  = 34'(sfp_pkg::PROG_CYC),
  parameter logic [33:0] SECT_CYCLES  = 34'(sfp_pkg::SECT_ERASE_CYC),
  parameter logic [33:0] BLOCK_CYCLES = 34'(sfp_pkg::BLOCK_ERASE_CYC),
  parameter logic [33:0] CHIP_CYCLES  = 34'(sfp_pkg::CHIP_ERASE_CYC),
  parameter logic [33:0] SRW_CYCLES   = 34'(sfp_pkg::STATUS_WR_CYC)
) (
  // Clock and reset
  input  wire logic               CLK_IN,
  input  wire logic               ARST_N_IN,
  // Serial pins
  input  wire logic               SCLK_IN,
  input  wire logic               CS_N_IN,
  input  wire logic [3:0]         LANE_IN,
  output logic      [3:0]         LANE_OUT,
  output logic      [3:0]         LANE_OE_OUT,
  // Decoder side of the stream
  input  wire sfp_pkg::sfp_lanes_t LANE_MODE_IN,
  input  wire logic               OUT_PHASE_IN,
  input  wire logic [3:0]         TX_DATA_IN,
  output logic                    TX_TAKE_OUT,
  output logic                    RX_VALID_OUT,
  output logic      [3:0]         RX_DATA_OUT,
  output logic                    SELECTED_OUT,
  // Protection
  input  wire logic [3:0]         BLOCK_PROTECT_IN,
  input  wire logic               STATUS_WRITE_LOCK_IN,
  output logic                    WP_ACTIVE_OUT,
  output logic                    SR_WRITE_BLOCKED_OUT,
  output logic                    ARRAY_HW_LOCK_OUT,
  // Array operations
  input  wire logic               OP_START_IN,
  input  wire sfp_pkg::sfp_op_t   OP_KIND_IN,
  input  wire logic [23:0]        OP_ADDR_IN,
  input  wire logic [8:0]         PROG_LEN_IN,
  input  wire logic [7:0]         PROG_OLD_IN,
  input  wire logic [7:0]         PROG_NEW_IN,
  output logic                    OP_BUSY_OUT,
  output logic                    OP_REJECT_OUT,
  output logic      [23:0]        RANGE_BASE_OUT,
  output logic      [23:0]        RANGE_LAST_OUT,
  output logic      [7:0]         PROG_MERGE_OUT,
  output sfp_pkg::sfp_map_t       MAP_OUT
);
  import sfp_pkg::*;

  typedef struct packed {
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_d;
    logic        cs_s1;
    logic        cs_s2;
    logic [3:0]  lane_s1;
    logic [3:0]  lane_s2;
    sfp_link_t   link;
    logic        rx_valid;
    logic [3:0]  rx_data;
    logic [3:0]  tx_data;
    logic [3:0]  oe;
    logic [33:0] busy_cnt;
    logic        reject;
    logic [23:0] base;
    logic [23:0] last;
    logic [7:0]  merge;
    sfp_map_t    map;
    logic        wp_active;
    logic        sr_blocked;
    logic        hw_lock;
  } sfp_state_t;

  sfp_state_t s_r;
  sfp_state_t s_nxt;
  logic       rise;
  logic       fall;
  logic       selected;
  logic       busy;
  logic       op_bad;
  logic [3:0] lane_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Edge finding on the sampled serial clock

  // Edges are only acted on while selected, so either idle level is fine
  assign rise     = s_r.sclk_s2 & ~s_r.sclk_d;
  assign fall     = ~s_r.sclk_s2 & s_r.sclk_d;
  assign selected = (s_r.link == ST_SEL);
  assign busy     = (s_r.busy_cnt != 34'h0);

  always_comb begin
    case (LANE_MODE_IN)
      LANES_TWO:  lane_mask = 4'h3;
      LANES_FOUR: lane_mask = 4'hf;
      default:    lane_mask = 4'h2;
    endcase
  end

  always_comb begin
    op_bad = 1'b0;
    case (OP_KIND_IN)
      OP_PROGRAM:      op_bad = (PROG_LEN_IN < PROG_MIN) || (PROG_LEN_IN > PROG_MAX);
      OP_SECTOR_ERASE: op_bad = 1'b0;
      OP_BLOCK_ERASE:  op_bad = 1'b0;
      OP_CHIP_ERASE:   op_bad = 1'b0;
      OP_STATUS_WRITE: op_bad = s_r.sr_blocked;
      OP_PAGE_ERASE:   op_bad = 1'b1;
      default:         op_bad = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt          = s_r;
    s_nxt.sclk_s1  = SCLK_IN;
    s_nxt.sclk_s2  = s_r.sclk_s1;
    s_nxt.sclk_d   = s_r.sclk_s2;
    s_nxt.cs_s1    = CS_N_IN;
    s_nxt.cs_s2    = s_r.cs_s1;
    s_nxt.lane_s1  = LANE_IN;
    s_nxt.lane_s2  = s_r.lane_s1;
    s_nxt.rx_valid = 1'b0;
    s_nxt.reject   = 1'b0;

    // Power-up holds off until a full high-then-low select is seen
    case (s_r.link)
      ST_WAIT_HIGH: if (s_r.cs_s2) begin
        s_nxt.link = ST_WAIT_LOW;
      end
      ST_WAIT_LOW: if (!s_r.cs_s2) begin
        s_nxt.link = ST_SEL;
      end
      ST_SEL: if (s_r.cs_s2) begin
        s_nxt.link = ST_IDLE;
      end
      ST_IDLE: if (!s_r.cs_s2) begin
        s_nxt.link = ST_SEL;
      end
      default: s_nxt.link = ST_WAIT_HIGH;
    endcase

    if (selected && rise && !OUT_PHASE_IN) begin
      s_nxt.rx_valid = 1'b1;
      case (LANE_MODE_IN)
        LANES_TWO:  s_nxt.rx_data = {2'h0, s_r.lane_s2[1:0]};
        LANES_FOUR: s_nxt.rx_data = s_r.lane_s2;
        default:    s_nxt.rx_data = {3'h0, s_r.lane_s2[0]};
      endcase
    end

    // Drive starts only at a falling edge, giving the host time to let go
    if (!selected || !OUT_PHASE_IN) begin
      s_nxt.oe = 4'h0;
    end else if (fall) begin
      s_nxt.oe = lane_mask;
      if (LANE_MODE_IN == LANES_TWO || LANE_MODE_IN == LANES_FOUR) begin
        s_nxt.tx_data = TX_DATA_IN & lane_mask;
      end else begin
        s_nxt.tx_data = {2'h0, TX_DATA_IN[0], 1'b0};
      end
    end

    // Quad mode turns the protect pin into data lane two
    s_nxt.wp_active  = ~s_r.lane_s2[2] && (LANE_MODE_IN != LANES_FOUR);
    s_nxt.sr_blocked = s_r.wp_active & STATUS_WRITE_LOCK_IN;
    s_nxt.hw_lock    = s_r.sr_blocked & (|BLOCK_PROTECT_IN);

    s_nxt.map.block  = OP_ADDR_IN[23:BLOCK_LSB];
    s_nxt.map.sector = OP_ADDR_IN[23:SECTOR_LSB];
    s_nxt.map.page   = OP_ADDR_IN[23:PAGE_LSB];
    s_nxt.map.offset = OP_ADDR_IN[PAGE_LSB-1:0];
    s_nxt.merge      = PROG_OLD_IN & PROG_NEW_IN;

    // Counter ignores select entirely so a started job always finishes
    if (busy) begin
      s_nxt.busy_cnt = s_r.busy_cnt - 34'h1;
    end
    if (OP_START_IN) begin
      if (busy || op_bad) begin
        s_nxt.reject = 1'b1;
      end else begin
        case (OP_KIND_IN)
          OP_PROGRAM: begin
            s_nxt.busy_cnt = PROG_CYCLES;
            s_nxt.base     = OP_ADDR_IN;
            // Bytes past the page end wrap within the same page
            s_nxt.last = {OP_ADDR_IN[23:8], OP_ADDR_IN[7:0] + 8'(PROG_LEN_IN - 9'h1)};
          end
          OP_SECTOR_ERASE: begin
            s_nxt.busy_cnt = SECT_CYCLES;
            s_nxt.base     = OP_ADDR_IN & ~SECTOR_MASK;
            s_nxt.last     = OP_ADDR_IN | SECTOR_MASK;
          end
          OP_BLOCK_ERASE: begin
            s_nxt.busy_cnt = BLOCK_CYCLES;
            s_nxt.base     = OP_ADDR_IN & ~BLOCK_MASK;
            s_nxt.last     = OP_ADDR_IN | BLOCK_MASK;
          end
          OP_CHIP_ERASE: begin
            s_nxt.busy_cnt = CHIP_CYCLES;
            s_nxt.base     = 24'h000000;
            s_nxt.last     = TOP_ADDR;
          end
          default: begin
            s_nxt.busy_cnt = SRW_CYCLES;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s_r         <= '0;
      // Protect pin idles high; a zero here would falsely lock status writes
      s_r.lane_s1 <= 4'h4;
      s_r.lane_s2 <= 4'h4;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign LANE_OUT             = s_r.tx_data;
  assign LANE_OE_OUT          = selected ? s_r.oe : 4'h0;
  assign TX_TAKE_OUT          = selected && fall && OUT_PHASE_IN;
  assign RX_VALID_OUT         = s_r.rx_valid;
  assign RX_DATA_OUT          = s_r.rx_data;
  assign SELECTED_OUT         = selected;
  assign WP_ACTIVE_OUT        = s_r.wp_active;
  assign SR_WRITE_BLOCKED_OUT = s_r.sr_blocked;
  assign ARRAY_HW_LOCK_OUT    = s_r.hw_lock;
  assign OP_BUSY_OUT          = busy;
  assign OP_REJECT_OUT        = s_r.reject;
  assign RANGE_BASE_OUT       = s_r.base;
  assign RANGE_LAST_OUT       = s_r.last;
  assign PROG_MERGE_OUT       = s_r.merge;
  assign MAP_OUT              = s_r.map;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  sequence tx_edge_seq(logic [1:0] m);
    selected && fall && OUT_PHASE_IN && !s_r.cs_s2 && LANE_MODE_IN == m;
  endsequence

  a_deselect_hiz: assert property (s_r.cs_s2 |=> LANE_OE_OUT == 4'h0)
    else $error("lanes driven while deselected");
  a_powerup_ignore: assert property (
    (s_r.link == ST_WAIT_HIGH || s_r.link == ST_WAIT_LOW) |=> !RX_VALID_OUT)
    else $error("input taken before first select");
  a_single_sample: assert property (
    (selected && rise && !OUT_PHASE_IN && LANE_MODE_IN == LANES_ONE)
    |=> RX_VALID_OUT && RX_DATA_OUT == {3'h0, $past(s_r.lane_s2[0])})
    else $error("lane zero not sampled on rise");
  a_rx_on_rise: assert property (RX_VALID_OUT |-> $past(rise))
    else $error("input sampled without rising edge");
  a_tx_on_fall: assert property ($changed(LANE_OUT) |-> $past(fall))
    else $error("output changed without falling edge");
  a_single_lane: assert property (tx_edge_seq(LANES_ONE)
    |=> LANE_OE_OUT == 4'h2 && LANE_OUT[1] == $past(TX_DATA_IN[0]))
    else $error("single lane output wrong");
  a_quad_lanes: assert property (tx_edge_seq(LANES_FOUR)
    |=> LANE_OE_OUT == 4'hf && LANE_OUT == $past(TX_DATA_IN))
    else $error("quad lane output wrong");
  a_busy_hold: assert property ((s_r.busy_cnt > 34'h1 && s_r.cs_s2) |=> OP_BUSY_OUT)
    else $error("operation stopped on deselect");
  a_quad_no_wp: assert property ((LANE_MODE_IN == LANES_FOUR) |=> !WP_ACTIVE_OUT)
    else $error("protect active in quad mode");
  a_sr_block: assert property (
    (OP_START_IN && OP_KIND_IN == OP_STATUS_WRITE && s_r.sr_blocked && !busy)
    |=> OP_REJECT_OUT && !OP_BUSY_OUT)
    else $error("blocked status write accepted");
  a_page_erase: assert property ((OP_START_IN && OP_KIND_IN == OP_PAGE_ERASE) |=> OP_REJECT_OUT)
    else $error("page erase accepted");
  a_prog_len: assert property (
    (OP_START_IN && OP_KIND_IN == OP_PROGRAM && (PROG_LEN_IN == 9'h0 || PROG_LEN_IN > 9'h100))
    |=> OP_REJECT_OUT)
    else $error("bad program length accepted");
  a_merge_and: assert property (##1 PROG_MERGE_OUT == ($past(PROG_OLD_IN) & $past(PROG_NEW_IN)))
    else $error("program set a bit");
  a_sector_map: assert property (##1 MAP_OUT.sector == $past(OP_ADDR_IN[23:12]))
    else $error("sector map wrong");
  a_dual_lanes: assert property (tx_edge_seq(LANES_TWO)
    |=> LANE_OE_OUT == 4'h3 && LANE_OUT == ($past(TX_DATA_IN) & 4'h3))
    else $error("dual lane output wrong");
  a_no_rx_desel: assert property (!selected |=> !RX_VALID_OUT)
    else $error("input taken while deselected");
  a_chip_range: assert property (
    (OP_START_IN && OP_KIND_IN == OP_CHIP_ERASE && !busy)
    |=> RANGE_BASE_OUT == 24'h000000 && RANGE_LAST_OUT == 24'hffffff)
    else $error("chip erase range wrong");
  a_block_range: assert property (
    (OP_START_IN && OP_KIND_IN == OP_BLOCK_ERASE && !busy)
    |=> RANGE_BASE_OUT == {$past(OP_ADDR_IN[23:16]), 16'h0000}
        && RANGE_LAST_OUT == {$past(OP_ADDR_IN[23:16]), 16'hffff})
    else $error("block erase range wrong");
endmodule
`default_nettype wire

/* sim/sfp_host_model.sv */
// Purpose: Behavioural host controller on the serial pins
// Assumes: Link clock period 125 ns, far below the core clock
// Notes:   Clock stands still outside frames at the idle level
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
  // Serial pins
  output logic       sclk_out,
  output logic       cs_n_out,
  output logic [3:0] drv_out,
  output logic [3:0] oe_out
);
  logic cpol = 1'b0;
  initial begin
    sclk_out = 1'b0;
    // Select already low at power-up
    cs_n_out = 1'b0;
    drv_out  = 4'hf;
    oe_out   = 4'hf;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic sel();
    sclk_out = cpol;
    #20 cs_n_out = 1'b0;
    #40;
  endtask
  task automatic desel();
    #20 sclk_out = cpol;
    #20 cs_n_out = 1'b1;
    // Take lanes back only once the port has let go
    #40 oe_out = 4'hf;
  endtask
  task automatic shift(input logic [3:0] d);
    drv_out = d;
    #2 sclk_out = 1'b0;
    #60.5 sclk_out = 1'b1;
    #62.5;
  endtask
  task automatic rd_bit();
    oe_out = 4'h0;
    #2 sclk_out = 1'b1;
    #60.5 sclk_out = 1'b0;
    #62.5;
  endtask
  task automatic wp(input logic v);
    drv_out[2] = v;
  endtask
endmodule
`default_nettype wire

/* sim/sfp_serial_port_tb_top.sv */
// Purpose: Self-checking bench of the serial port front end
// Assumes: Short operation counts set by parameter
// Notes:   Lanes nobody drives toggle, so a stale level never passes
`timescale 1ns/1ps
`default_nettype none
module sfp_serial_port_tb_top;
  import sfp_pkg::*;
  logic        CLK_IN = 1'b0, ARST_N_IN = 1'b0, OUT_PHASE_IN = 1'b0, OP_START_IN = 1'b0;
  logic        STATUS_WRITE_LOCK_IN = 1'b0, tog = 1'b0, lk, w, x;
  logic [3:0]  TX_DATA_IN = 4'h0, BLOCK_PROTECT_IN = 4'h0, rx_last, v, b;
  sfp_lanes_t  LANE_MODE_IN = LANES_ONE, m;
  sfp_op_t     OP_KIND_IN = OP_PROGRAM;
  logic [23:0] OP_ADDR_IN = 24'h000000, RANGE_BASE_OUT, RANGE_LAST_OUT, a;
  logic [8:0]  PROG_LEN_IN = 9'h001, n;
  logic [7:0]  PROG_OLD_IN = 8'h00, PROG_NEW_IN = 8'h00, PROG_MERGE_OUT;
  logic [3:0]  LANE_OUT, LANE_OE_OUT, RX_DATA_OUT;
  logic        TX_TAKE_OUT, RX_VALID_OUT, SELECTED_OUT, WP_ACTIVE_OUT, SR_WRITE_BLOCKED_OUT;
  logic        ARRAY_HW_LOCK_OUT, OP_BUSY_OUT, OP_REJECT_OUT;
  sfp_map_t    MAP_OUT;
  wire logic   SCLK_IN, CS_N_IN;
  wire logic [3:0] h_drv, h_oe, LANE_IN;
  int          errors = 0, samples_checked = 0, rx_cnt = 0, take_cnt = 0, n0, t0;
  sfp_lanes_t  modes [3] = '{LANES_ONE, LANES_TWO, LANES_FOUR};
  sfp_op_t     ek [3] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE};
  logic [23:0] em [3] = '{SECTOR_MASK, BLOCK_MASK, TOP_ADDR};
  sfp_op_t     rk [4] = '{OP_PAGE_ERASE, sfp_op_t'(3'h6), OP_PROGRAM, OP_PROGRAM};
  logic [8:0]  rl [4] = '{9'h001, 9'h001, 9'h000, 9'h101};
  ////////////////////////////////////////////////////////////////////////
  assign LANE_IN = (LANE_OE_OUT & LANE_OUT) | (~LANE_OE_OUT & h_oe & h_drv)
                 | (~LANE_OE_OUT & ~h_oe & {4{tog}});
  sfp_serial_port #(.PROG_CYCLES(34'h14), .SECT_CYCLES(34'h1e), .BLOCK_CYCLES(34'h28),
    .CHIP_CYCLES(34'h32)) sfp_serial_port_i (.CLK_IN, .ARST_N_IN,
    .SCLK_IN, .CS_N_IN, .LANE_IN, .LANE_OUT, .LANE_OE_OUT, .LANE_MODE_IN, .OUT_PHASE_IN,
    .TX_DATA_IN, .TX_TAKE_OUT, .RX_VALID_OUT, .RX_DATA_OUT, .SELECTED_OUT,
    .BLOCK_PROTECT_IN, .STATUS_WRITE_LOCK_IN, .WP_ACTIVE_OUT, .SR_WRITE_BLOCKED_OUT,
    .ARRAY_HW_LOCK_OUT, .OP_START_IN, .OP_KIND_IN, .OP_ADDR_IN, .PROG_LEN_IN,
    .PROG_OLD_IN, .PROG_NEW_IN, .OP_BUSY_OUT, .OP_REJECT_OUT, .RANGE_BASE_OUT,
    .RANGE_LAST_OUT, .PROG_MERGE_OUT, .MAP_OUT);
  sfp_host_model sfp_host_model_i (.sclk_out(SCLK_IN), .cs_n_out(CS_N_IN),
    .drv_out(h_drv), .oe_out(h_oe));
  ////////////////////////////////////////////////////////////////////////
  always #2.5 CLK_IN = ~CLK_IN;
  // Counted on the falling edge, where registered pulses have settled
  always @(negedge CLK_IN) begin
    tog <= ~tog;
    if (RX_VALID_OUT === 1'b1) begin
      rx_cnt++;
      rx_last = RX_DATA_OUT;
    end
    if (TX_TAKE_OUT === 1'b1)
      take_cnt++;
  end
  function automatic logic [3:0] lmask(sfp_lanes_t md);
    return (md == LANES_FOUR) ? 4'hf : (md == LANES_TWO) ? 4'h3 : 4'h1;
  endfunction
  function automatic logic [3:0] txoe(sfp_lanes_t md);
    return (md == LANES_ONE) ? 4'h2 : lmask(md);
  endfunction
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic op(input sfp_op_t k, input logic [23:0] ad, input logic [8:0] ln);
    @(posedge CLK_IN);
    OP_START_IN <= 1'b1;
    OP_KIND_IN  <= k;
    OP_ADDR_IN  <= ad;
    PROG_LEN_IN <= ln;
    PROG_OLD_IN <= 8'($urandom);
    PROG_NEW_IN <= 8'($urandom);
    @(posedge CLK_IN);
    OP_START_IN <= 1'b0;
    #1;
    check("merge", PROG_MERGE_OUT, PROG_OLD_IN & PROG_NEW_IN);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      if (OP_BUSY_OUT === 1'b0)
        return;
      @(posedge CLK_IN);
      #1;
    end
    errors++;
    final_report();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(27));
    repeat (6) @(posedge CLK_IN);
    ARST_N_IN <= 1'b1;
    @(posedge CLK_IN);
    #1;
    check("reset busy", OP_BUSY_OUT, 1'b0);
    check("reset oe", LANE_OE_OUT, 4'h0);
    sfp_host_model_i.shift(4'h1);
    check("early rx", 48'(rx_cnt), 48'h0);
    check("early sel", SELECTED_OUT, 1'b0);
    sfp_host_model_i.desel();
    $display("test power-up done");
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 24'hfffabc : 24'($urandom);
      op(ek[i], a, 9'h001);
      check("erase busy", OP_BUSY_OUT, 1'b1);
      check("base", RANGE_BASE_OUT, a & ~em[i]);
      check("last", RANGE_LAST_OUT, a | em[i]);
      check("map", MAP_OUT, {a[23:16], a[23:12], a[23:8], a[7:0]});
      wait_idle();
    end
    sfp_host_model_i.sel();
    op(OP_CHIP_ERASE, 24'h000000, 9'h001);
    op(OP_SECTOR_ERASE, 24'h001000, 9'h001);
    check("busy start", OP_REJECT_OUT, 1'b1);
    sfp_host_model_i.desel();
    check("run on", OP_BUSY_OUT, 1'b1);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      op(rk[i], 24'($urandom), rl[i]);
      check("reject", OP_REJECT_OUT, 1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      a = 24'($urandom);
      n = (i == 0) ? 9'h100 : 9'(1 + $urandom_range(254));
      op(OP_PROGRAM, a, n);
      check("prog busy", OP_BUSY_OUT, 1'b1);
      check("prog last", RANGE_LAST_OUT, {a[23:8], 8'(a[7:0] + n - 1)});
      wait_idle();
    end
    $display("test operations done");
    for (int i = 0; i < 6; i++) begin
      m = modes[i % 3];
      lk = (i == 0) ? 1'b1 : 1'($urandom);
      b = (i == 0) ? 4'h4 : 4'($urandom);
      w = (i < 3) ? 1'b0 : 1'($urandom);
      @(posedge CLK_IN);
      LANE_MODE_IN <= m;
      STATUS_WRITE_LOCK_IN <= lk;
      BLOCK_PROTECT_IN <= b;
      sfp_host_model_i.wp(w);
      // Pin sync plus three register stages
      repeat (8) @(posedge CLK_IN);
      #1;
      x = !w && m != LANES_FOUR;
      check("wp", WP_ACTIVE_OUT, x);
      check("sr lock", SR_WRITE_BLOCKED_OUT, x && lk);
      check("array lock", ARRAY_HW_LOCK_OUT, x && lk && b != 4'h0);
      op(OP_STATUS_WRITE, 24'h000000, 9'h001);
      check("sr write", OP_REJECT_OUT, x && lk);
      wait_idle();
    end
    $display("test protect done");
    for (int i = 0; i < 9; i++) begin
      m = modes[i % 3];
      sfp_host_model_i.cpol = i[0];
      v = 4'($urandom);
      @(posedge CLK_IN);
      LANE_MODE_IN <= m;
      OUT_PHASE_IN <= (i > 5);
      TX_DATA_IN <= v;
      n0 = rx_cnt;
      t0 = take_cnt;
      sfp_host_model_i.sel();
      check("selected", SELECTED_OUT, 1'b1);
      if (i < 6) begin
        sfp_host_model_i.shift(v);
        check("rx count", 48'(rx_cnt - n0), 48'h1);
        check("rx data", rx_last, v & lmask(m));
      end else begin
        sfp_host_model_i.rd_bit();
        check("oe", LANE_OE_OUT, txoe(m));
        check("out", LANE_OUT & txoe(m), (m == LANES_ONE) ? {2'b00, v[0], 1'b0} : (v & lmask(m)));
        check("take", 48'(take_cnt - t0), 48'h1);
        check("no rx", 48'(rx_cnt - n0), 48'h0);
      end
      sfp_host_model_i.desel();
      check("released", LANE_OE_OUT, 4'h0);
    end
    $display("test link done");
    final_report();
  end
endmodule
`default_nettype wire
